// ===== hw/lsdc_map.vh
// lsdc_map.vh: address map, field positions and reset values of the
// low-side driver register bank. definitions only.
`ifndef LSDC_MAP_VH
`define LSDC_MAP_VH
`define LSDC_BASE_BLOCKING 16'h0200
`define LSDC_BASE_NONBLOCK 16'h0300
`define LSDC_OFF_CONTROL 8'h30
`define LSDC_OFF_STATUS 8'h31
`define LSDC_OFF_UNLOCK 8'h32
`define LSDC_UNLOCK_KEY 4'h5
`define LSDC_CTRL_RESET 8'h00
`define LSDC_UNLOCK_RESET 4'h0
`define LSDC_CTRL_WMASK 8'hbf
`define LSDC_BIT_OT_IRQ_EN 7
`define LSDC_BIT_SEL_TWO 5
`define LSDC_BIT_SEL_ONE 4
`define LSDC_BIT_PWM_TWO 3
`define LSDC_BIT_PWM_ONE 2
`define LSDC_BIT_EN_TWO 1
`define LSDC_BIT_EN_ONE 0
`define LSDC_BIT_OT_COND 7
`endif

// ===== hw/lsdc_regs.v
// lsdc_regs.v: low-side driver control, status and unlock registers.
// assumes a single-cycle die-to-die register port on CORE_CLK_I and
// analog status inputs arriving asynchronously.
`timescale 1ns/1ps
`default_nettype none
`include "lsdc_map.vh"
// Summary of operation
// [RQ1] control, status, unlock decoded at offsets 0x30, 0x31, 0x32.
// [RQ2] registers reachable at base 0x0200 blocking and 0x300 non-blocking.
// [RQ3] control bit 7 enables the overtemperature interrupt.
// [RQ4] control bits 5/4 pick pwm channel for drivers two/one.
// [RQ5] control bits 3/2 enable pwm modulation of drivers two/one.
// [RQ6] control bits 1/0 switch drivers two/one only once unlocked.
// [RQ7] driver enables honoured only while unlock field holds the key.
// [RQ8] unlock value 0x5 enables control, all others disable it.
// [RQ9] status bit 7 shows overtemperature; both drivers held off meanwhile.
// [RQ10] reading status clears the latched overtemperature interrupt flag.
// [RQ11] status bits 3/2 show current limitation of drivers two/one.
// [RQ12] status bits 1/0 show open load of drivers two/one.
// [RQ13] status register is read-only; writes have no effect.
// [RQ14] all registers reset to zero; unused bits read zero.
// [RQ15] software writes the key after reset and after regulator overvoltage.
// [RQ16] regulator overvoltage clears both driver enable bits.
// [RQ17] after overtemperature, a control write turns drivers on again.
// [RQ18] open-load bits never flag while a driver is off.
module lsdc_regs (
    input wire CORE_CLK_I,
    input wire RESET_I,
    input wire [15:0] ADDR_I,
    input wire WR_I,
    input wire RD_I,
    input wire [7:0] WDATA_I,
    output reg [7:0] RDATA_O,
    output wire HIT_O,
    input wire [1:0] PWM_CHAN_I,
    input wire OVERTEMP_I,
    input wire REG_OVERVOLT_I,
    input wire [1:0] CUR_LIMIT_I,
    input wire [1:0] OPEN_LOAD_I,
    output reg [1:0] DRIVER_ON_O,
    output wire OVERTEMP_IRQ_O
);

    // window bases, full width so the compare keeps its size
    localparam [15:0] BASE_BLK = `LSDC_BASE_BLOCKING;
    localparam [15:0] BASE_NBK = `LSDC_BASE_NONBLOCK;
    localparam [7:0] OFF_NONE = 8'hff;

    // offset of an address in either window, or OFF_NONE outside
    function [7:0] win_off;
        input [15:0] a;
        begin
            if (a[15:8] == BASE_BLK[15:8] ||
                    a[15:8] == BASE_NBK[15:8]) begin // [RQ2]
                win_off = a[7:0];
            end else begin
                win_off = OFF_NONE;
            end
        end
    endfunction

    // match of a window offset against one register
    function is_off;
        input [7:0] o;
        input [7:0] want;
        begin
            is_off = (o == want);
        end
    endfunction

    // synchronised analog status, first and second stage
    reg [6:0] sync_a_q;
    reg [6:0] sync_b_q;

    // register state and next values
    reg [7:0] ctrl_q;
    reg [7:0] ctrl_d;
    reg [3:0] unlock_q;
    reg [3:0] unlock_d;
    reg irq_flag_q;
    reg irq_flag_d;
    reg shut_q;
    reg shut_d;
    reg [7:0] rdata_d;

    // decode
    wire [7:0] off;
    wire sel_ctrl;
    wire sel_stat;
    wire sel_unl;
    wire wr_ctrl;
    wire wr_unl;
    wire rd_stat;

    // status views
    wire ot;
    wire ov;
    wire [1:0] cl;
    wire [1:0] ol;
    wire unlocked;
    wire [1:0] pwm_lvl;
    wire [1:0] driver_on_d;
    wire [7:0] status;

    assign off = win_off(ADDR_I);
    assign sel_ctrl = is_off(off, `LSDC_OFF_CONTROL); // [RQ1]
    assign sel_stat = is_off(off, `LSDC_OFF_STATUS); // [RQ1]
    assign sel_unl = is_off(off, `LSDC_OFF_UNLOCK); // [RQ1]
    assign wr_ctrl = WR_I & sel_ctrl;
    assign wr_unl = WR_I & sel_unl;
    assign rd_stat = RD_I & sel_stat;

    assign ot = sync_b_q[0];
    assign ov = sync_b_q[1];
    assign cl = sync_b_q[3:2];
    assign ol = sync_b_q[5:4];
    assign unlocked = (unlock_q == `LSDC_UNLOCK_KEY); // [RQ7] [RQ8]

    assign HIT_O = sel_ctrl | sel_stat | sel_unl;
    assign OVERTEMP_IRQ_O = irq_flag_q;

    // two-flop synchronisers for analog status
    always @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            sync_a_q <= 7'h00;
            sync_b_q <= 7'h00;
        end else begin
            sync_a_q <= {1'b0, OPEN_LOAD_I, CUR_LIMIT_I, REG_OVERVOLT_I,
                OVERTEMP_I};
            sync_b_q <= sync_a_q;
        end
    end

    // control register; overvoltage beats a write of the enables
    always @* begin
        ctrl_d = ctrl_q;
        if (wr_ctrl) begin
            ctrl_d = WDATA_I & `LSDC_CTRL_WMASK; // [RQ3] [RQ4] [RQ5] [RQ14]
        end
        if (ov) begin
            ctrl_d[`LSDC_BIT_EN_TWO] = 1'b0; // [RQ16]
            ctrl_d[`LSDC_BIT_EN_ONE] = 1'b0; // [RQ16]
        end
    end

    // unlock key field
    always @* begin
        unlock_d = unlock_q;
        if (wr_unl) begin
            unlock_d = WDATA_I[3:0]; // [RQ7]
        end
    end

    // overtemperature shutdown latch
    always @* begin
        shut_d = shut_q;
        if (ot) begin
            shut_d = 1'b1; // [RQ9]
        end else if (wr_ctrl) begin
            shut_d = 1'b0; // [RQ17]
        end
    end

    // interrupt flag; set wins over the read clear
    always @* begin
        irq_flag_d = irq_flag_q;
        if (ot && ctrl_q[`LSDC_BIT_OT_IRQ_EN]) begin
            irq_flag_d = 1'b1; // [RQ3]
        end else if (rd_stat) begin
            irq_flag_d = 1'b0; // [RQ10]
        end
    end

    // status image; open load masked while a driver is off
    assign status = {ot, 3'b000, cl,
        ol & DRIVER_ON_O}; // [RQ9] [RQ11] [RQ12] [RQ18] [RQ14]

    // read data; status writes are not decoded
    always @* begin
        rdata_d = RDATA_O;
        if (RD_I) begin
            if (sel_ctrl) begin
                rdata_d = ctrl_q;
            end else if (sel_stat) begin
                rdata_d = status; // [RQ13]
            end else if (sel_unl) begin
                rdata_d = {4'h0, unlock_q}; // [RQ14]
            end else begin
                rdata_d = 8'h00;
            end
        end
    end

    // register state
    always @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            ctrl_q <= `LSDC_CTRL_RESET; // [RQ14]
            unlock_q <= `LSDC_UNLOCK_RESET; // [RQ14]
            irq_flag_q <= 1'b0;
            shut_q <= 1'b0;
            RDATA_O <= 8'h00;
        end else begin
            ctrl_q <= ctrl_d;
            unlock_q <= unlock_d;
            irq_flag_q <= irq_flag_d;
            shut_q <= shut_d;
            RDATA_O <= rdata_d;
        end
    end

    // per-driver gate command
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : drv
            wire sel;
            wire pen;
            assign sel = ctrl_q[`LSDC_BIT_SEL_ONE + g];
            assign pen = ctrl_q[`LSDC_BIT_PWM_ONE + g];
            assign pwm_lvl[g] = pen ? PWM_CHAN_I[sel] : 1'b1; // [RQ4] [RQ5]
            assign driver_on_d[g] = ctrl_q[`LSDC_BIT_EN_ONE + g] &
                unlocked & ~shut_q & ~ot & pwm_lvl[g]; // [RQ6] [RQ9]
        end
    endgenerate

    // output register of both driver gate outputs
    always @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            DRIVER_ON_O <= 2'b00;
        end else begin
            DRIVER_ON_O <= driver_on_d;
        end
    end

endmodule // lsdc_regs
`default_nettype wire

// ===== verif/lsdc_sva.sv
// lsdc_sva: port checks of lsdc_regs
// assumes sync active-high reset
`timescale 1ns/1ps
`default_nettype none
module lsdc_sva (
    input wire logic CORE_CLK_I, RESET_I, RD_I, HIT_O, OVERTEMP_I,
    input wire logic REG_OVERVOLT_I, OVERTEMP_IRQ_O,
    input wire logic [15:0] ADDR_I,
    input wire logic [7:0] RDATA_O,
    input wire logic [1:0] DRIVER_ON_O
);
    default clocking @(posedge CORE_CLK_I); endclocking
    default disable iff (RESET_I);
    sequence s_rd(o);
        RD_I && HIT_O && ADDR_I[7:0] == o;
    endsequence
    a_hit_dec: assert property (
        HIT_O == (ADDR_I[15:9] == 7'h01 && ADDR_I[7:0] > 8'h2f
        && ADDR_I[7:0] < 8'h33)) else $error("hit");
    a_ot_off: assert property (
        OVERTEMP_I[*6] |-> DRIVER_ON_O == 2'h0) else $error("ot");
    a_ov_off: assert property (
        REG_OVERVOLT_I[*6] |-> DRIVER_ON_O == 2'h0) else $error("ov");
    a_irq_clr: assert property (
        (!OVERTEMP_I)[*4] ##0 s_rd(8'h31) |=> !OVERTEMP_IRQ_O) else $error("i");
    a_st_zero: assert property (
        s_rd(8'h31) |=> RDATA_O[6:4] == 3'h0) else $error("st");
    a_key_zero: assert property (
        s_rd(8'h32) |=> RDATA_O[7:4] == 4'h0) else $error("key");
    a_ctl_zero: assert property (
        s_rd(8'h30) |=> !RDATA_O[6]) else $error("ctl");
    a_rd_unmap: assert property (
        RD_I && !HIT_O |=> RDATA_O == 8'h00) else $error("unm");
endmodule // lsdc_sva
`default_nettype wire

// ===== verif/lsdc_mcu.sv
// lsdc_mcu: register master model
// assumes strobes sampled on rising edge
`timescale 1ns/1ps
`default_nettype none
module lsdc_mcu (
    input wire logic clk_i,
    output logic [15:0] addr_o,
    output logic wr_o,
    output logic rd_o,
    output logic [7:0] wdata_o
);
    // idle address lies outside both windows
    localparam logic [15:0] IDLE_ADDR = 16'hfdcf;
    initial begin
        addr_o = IDLE_ADDR;
        wr_o = 1'b0;
        rd_o = 1'b0;
        wdata_o = 8'h00;
    end
    // one single-cycle access, strobe up for exactly one rising edge
    task automatic acc(input logic [15:0] a, input logic w,
            input logic [7:0] d);
        @(posedge clk_i);
        addr_o <= a;
        wr_o <= w;
        rd_o <= !w;
        wdata_o <= d;
        @(posedge clk_i);
        wr_o <= 1'b0;
        rd_o <= 1'b0;
        addr_o <= IDLE_ADDR;
    endtask
endmodule // lsdc_mcu
`default_nettype wire

// ===== verif/lsdc_regs_tb.sv
// lsdc_regs_tb: self-checking bench
// assumes lsdc_mcu drives the register port
`timescale 1ns/1ps
`default_nettype none
module lsdc_regs_tb;
    logic clk, rst, ot, ov, wr, rd, irq, hit;
    logic [1:0] pwm, cl, ol, drv;
    logic [15:0] a;
    logic [7:0] wd, rdat, c;
    int bad_count, n_checks, seed, i;
    lsdc_mcu i_mcu (.clk_i(clk), .addr_o(a), .wr_o(wr), .rd_o(rd),
        .wdata_o(wd));
    lsdc_regs i_dut (.CORE_CLK_I(clk), .RESET_I(rst), .ADDR_I(a),
        .WR_I(wr), .RD_I(rd), .WDATA_I(wd), .RDATA_O(rdat), .HIT_O(hit),
        .PWM_CHAN_I(pwm), .OVERTEMP_I(ot), .REG_OVERVOLT_I(ov),
        .CUR_LIMIT_I(cl), .OPEN_LOAD_I(ol), .DRIVER_ON_O(drv),
        .OVERTEMP_IRQ_O(irq));
    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    task automatic chk(input logic [7:0] g, e);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // random blocking or non-blocking base
    task automatic acc(input logic [7:0] o, input logic w, [7:0] d);
        i_mcu.acc({7'h01, 1'($random(seed)), o}, w, d);
    endtask
    task automatic rdc(input logic [7:0] o, e);
        acc(o, 1'b0, 8'h00);
        #1 chk(rdat, e);
    endtask
    task automatic dchk(input logic [1:0] e, input int n);
        repeat (n) @(posedge clk);
        #1 chk(8'(drv), 8'(e));
    endtask
    function automatic logic [1:0] xd(input logic [7:0] c, [1:0] p);
        for (int k = 0; k < 2; k++)
            xd[k] = c[k] & (!c[k+2] | p[c[k+4]]);
    endfunction
    task automatic final_report;
        $display("checks %0d errors %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        seed = 27;
        {rst, ot, ov, pwm, cl, ol} = 9'h100;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        for (i = 0; i < 3; i++) rdc(8'h30 + 8'(i), 8'h00);
        rdc(8'h40, 8'h00);
        acc(8'h30, 1'b1, 8'h03);
        dchk(2'h0, 3);
        acc(8'h32, 1'b1, 8'hf5);
        dchk(2'h3, 3);
        rdc(8'h32, 8'h05);
        acc(8'h32, 1'b1, 8'h0d);
        dchk(2'h0, 3);
        acc(8'h32, 1'b1, 8'h05);
        for (i = 0; i < 40; i++) begin
            c = 8'($random(seed));
            {pwm, cl, ol} <= 6'($random(seed));
            acc(8'h31, 1'b1, 8'hff);
            acc(8'h30, 1'b1, c);
            dchk(xd(c, pwm), 3);
            rdc(8'h30, c & 8'hbf);
            rdc(8'h31, {4'h0, cl, ol & xd(c, pwm)});
        end
        acc(8'h30, 1'b1, 8'h83);
        ot <= 1'b1;
        dchk(2'h0, 6);
        chk(8'(irq), 8'h01);
        rdc(8'h31, {4'h8, cl, 2'h0});
        ot <= 1'b0;
        dchk(2'h0, 4);
        rdc(8'h31, {4'h0, cl, 2'h0});
        chk(8'(irq), 8'h00);
        acc(8'h30, 1'b1, 8'h83);
        dchk(2'h3, 3);
        ov <= 1'b1;
        dchk(2'h0, 6);
        rdc(8'h30, 8'h80);
        final_report();
    end
endmodule // lsdc_regs_tb
bind lsdc_regs lsdc_sva i_sva (.CORE_CLK_I, .RESET_I, .RD_I, .HIT_O,
    .OVERTEMP_I, .REG_OVERVOLT_I, .OVERTEMP_IRQ_O, .ADDR_I, .RDATA_O,
    .DRIVER_ON_O);
`default_nettype wire
